//--- common/lpmc_pkg.sv
// Purpose: shared constants and types of the low power mode controller
// Assumes: 32-bit register port, byte addresses as printed
// Notes: offsets are full byte addresses, data in the low bits

// ********************************************************************
// Constants
// ********************************************************************
package lpmc_pkg;
  localparam logic [31:0] LPC_ADDR = 32'h1000_0004;
  localparam logic [31:0] PCG_ADDR = 32'h1000_0020;
  localparam logic [31:0] OPC_ADDR = 32'h1000_0024;
  localparam logic [31:0] LOCK_ADDR = 32'h1000_0028;
  localparam logic [31:0] LPC_RESET = 32'h0000_00F8;
  localparam logic [31:0] PCG_RESET = 32'h0000_0000;
  localparam logic [31:0] OPC_RESET = 32'h0000_1500;
  localparam logic [31:0] LOCK_RESET = 32'h0000_0100;
  localparam logic [31:0] LPC_MASK = 32'h0000_00FF;
  localparam logic [31:0] PCG_MASK = 32'h1FFF_FFFF;
  localparam logic [31:0] OPC_MASK = 32'h0000_FF74;
  localparam logic [31:0] LOCK_MASK = 32'h0000_FFFF;
  localparam int DUTY_LSB = 3;
  localparam int DUTY_W = 5;
  localparam int DOZE_BIT = 2;
  localparam int PSS_LSB = 0;
  localparam int PSS_W = 2;
  localparam logic [1:0] PSS_IDLE = 2'h0;
  localparam logic [1:0] PSS_SLEEP = 2'h1;
  localparam int PCG_W = 29;
  localparam int UDC_BIT = 10;
  localparam int SETTLE_LSB = 8;
  localparam int SETTLE_W = 8;
  localparam int SPN_BIT = 6;
  localparam int BPM_BIT = 5;
  localparam int KEEP_BIT = 4;
  localparam int SLOW_BIT = 2;
  localparam int SETTLE_SHIFT = 4;
  localparam int LOCK_W = 16;
  localparam int DIV_W = 9;
  localparam logic [4:0] DUTY_MAX = 5'h1F;
  localparam logic [4:0] SLOT_LAST = 5'h1E;
  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE_WAIT, ST_IDLE, ST_DRAIN, ST_SREF, ST_SLEEP, ST_OSC, ST_LOCK
  } lpmc_state_t;
endpackage

//--- common/lpmc_duty_if.sv
// Purpose: link between mode control and the doze slot generator
// Assumes: one clock domain
// Notes: clk_on low means the current slot has expired
`timescale 1ns/10ps
`default_nettype none
interface lpmc_duty_if;
  logic enable;
  logic [4:0] duty;
  logic clk_on;
  modport ctl (output enable, output duty, input clk_on);
  modport gen (input enable, input duty, output clk_on);
endinterface
`default_nettype wire

//--- hw/lpmc_duty_slot.sv
// Purpose: doze burst slot generator, period of 31 cycles
// Assumes: duty may change at any time
// Notes: output is continuous while not enabled
`timescale 1ns/10ps
`default_nettype none
module lpmc_duty_slot (
  input wire logic core_clk,
  input wire logic nrst,
  lpmc_duty_if.gen dif
);
  logic [4:0] cnt;
  logic on;
  wire logic [4:0] next_cnt = (cnt == lpmc_pkg::SLOT_LAST) ? 5'h00 : cnt + 5'h01;

  // ******************************************************************
  // Slot counter
  // ******************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst || !dif.enable) begin
      cnt <= 5'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Duty of 31 never drops, duty 0 never rises
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      on <= 1'b1;
    end else begin
      on <= !dif.enable || (cnt < dif.duty); // RQ2
    end
  end
  assign dif.clk_on = on;

  duty_full_a: assert property (@(posedge core_clk) disable iff (!nrst)
    dif.enable && dif.duty == lpmc_pkg::DUTY_MAX |=> dif.clk_on) // RQ2
    else $error("full duty dropped the clock");
  duty_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    dif.enable && dif.duty == 5'h00 |=> !dif.clk_on) // RQ2
    else $error("zero duty let the clock run");
endmodule
`default_nettype wire

//--- hw/lpmc_ctrl.sv
// Contract
// RQ1: Doze bit gates only the CPU clock in bursts set by duty.
// RQ2: Duty field bits 7:3 gives on-time value/31; 31 always on, 0 off.
// RQ3: Doze ends on software clear, interrupt, reset or sleep instruction.
// RQ4: Any doze cancel clears the doze bit in hardware.
// RQ5: After doze cancel the CPU clock runs continuously at once.
// RQ6: Other clocks keep running during doze.
// RQ7: Expired CPU time slot halts the CPU, registers kept.
// RQ8: Software programs duty before setting doze, may change it later.
// RQ9: State select bits 1:0: 00 idle, 01 sleep, others reserved.
// RQ10: Idle stops CPU clock after current operation; system clocks stay.
// RQ11: Idle ends on any interrupt or reset.
// RQ12: Sleep stops all clocks but RTC, PLL off, clock pin stopped.
// RQ13: Sleep entry: arbiter stops granting, then SDRAM enters self-refresh.
// RQ14: Clocks stop only with bus idle and self-refresh confirmed.
// RQ15: Sleep ends on interrupt, watchdog reset or power-on reset.
// RQ16: Leaving sleep restarts PLL and waits lock time before clocks.
// RQ17: Software stops all peripherals before selecting sleep.
// RQ18: Gate bits 28:0 stop peripheral clock and access; clear or reset restores.
// RQ19: USB gate bit 10: 0 always runs, 1 stops only in suspend.
// RQ20: Oscillator settle bits 15:8 in units of 16 RTC periods, reset 0x15.
// RQ21: Bit 4 keeps main oscillator running in sleep when set.
// RQ22: Bit 2 selects main clock /512 or RTC clock as slow tick.
// RQ23: Bit 6 low forces USB phy suspend, high leaves it free.
// RQ24: One-cycle sleep request answered by halt held until wake.
//
// Purpose: low power mode controller, doze, idle, sleep and clock gating
// Assumes: resets of any source arrive on nrst; irq from same clock
// Notes: rtc_domain_clock is sampled, not used as a clock
`timescale 1ns/10ps
`default_nettype none
module lpmc_ctrl (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic cpu_op_done,
  input wire logic irq,
  input wire logic bus_idle,
  input wire logic sdram_sr_ack,
  input wire logic udc_suspend,
  input wire logic rtc_domain_clock,
  output logic cpu_clk_en,
  output logic cpu_halt,
  output logic sys_clk_en,
  output logic pll_en,
  output logic clock_output_pin_en,
  output logic osc_en,
  output logic arb_hold,
  output logic sdram_sr_req,
  output logic [28:0] periph_clk_en,
  output logic [28:0] periph_access_block,
  output logic slow_tick,
  output logic usb_phy_force,
  output logic bypass_select
);
  logic [31:0] lpc;
  logic [31:0] pcg;
  logic [31:0] opc;
  logic [31:0] lock_time;
  lpmc_pkg::lpmc_state_t state;
  lpmc_pkg::lpmc_state_t next_state;
  logic [15:0] cnt;
  logic [8:0] div;
  logic rtc_s1;
  logic rtc_s2;
  logic rtc_s3;
  lpmc_duty_if dif ();

  // ******************************************************************
  // Register port decode
  // ******************************************************************
  wire logic wr_lpc = reg_wr && reg_addr == lpmc_pkg::LPC_ADDR;
  wire logic wr_pcg = reg_wr && reg_addr == lpmc_pkg::PCG_ADDR;
  wire logic wr_opc = reg_wr && reg_addr == lpmc_pkg::OPC_ADDR;
  wire logic wr_lock = reg_wr && reg_addr == lpmc_pkg::LOCK_ADDR;
  wire logic [31:0] rd_mux =
    reg_addr == lpmc_pkg::LPC_ADDR ? lpc :
    reg_addr == lpmc_pkg::PCG_ADDR ? pcg :
    reg_addr == lpmc_pkg::OPC_ADDR ? opc :
    reg_addr == lpmc_pkg::LOCK_ADDR ? lock_time : 32'h0000_0000;

  // ******************************************************************
  // Field views
  // ******************************************************************
  wire logic doze = lpc[lpmc_pkg::DOZE_BIT];
  wire logic [4:0] duty = lpc[lpmc_pkg::DUTY_LSB +: lpmc_pkg::DUTY_W];
  wire logic [1:0] pss = lpc[lpmc_pkg::PSS_LSB +: lpmc_pkg::PSS_W];
  wire logic [28:0] gate = pcg[lpmc_pkg::PCG_W-1:0];
  wire logic [7:0] settle = opc[lpmc_pkg::SETTLE_LSB +: lpmc_pkg::SETTLE_W];
  wire logic keep_osc = opc[lpmc_pkg::KEEP_BIT];
  wire logic slow_sel = opc[lpmc_pkg::SLOW_BIT];
  wire logic [15:0] lock_cnt = lock_time[lpmc_pkg::LOCK_W-1:0];

  // ******************************************************************
  // Doze control
  // ******************************************************************
  // Reserved state codes make the sleep request a no-op
  wire logic take_idle = sleep_req && pss == lpmc_pkg::PSS_IDLE; // RQ9
  wire logic take_sleep = sleep_req && pss == lpmc_pkg::PSS_SLEEP; // RQ9
  wire logic in_run = state == lpmc_pkg::ST_RUN;
  wire logic doze_cancel = doze && (irq || take_idle || take_sleep); // RQ3
  // A software write in the same cycle wins over the hardware clear
  wire logic [31:0] lpc_wr = reg_wdata & lpmc_pkg::LPC_MASK;
  wire logic [31:0] lpc_hw = lpc & ~(32'h0000_0001 << lpmc_pkg::DOZE_BIT);
  wire logic [31:0] next_lpc = wr_lpc ? lpc_wr : (doze_cancel ? lpc_hw : lpc); // RQ4

  assign dif.enable = doze && in_run; // RQ1
  assign dif.duty = duty; // RQ2

  lpmc_duty_slot u_slot (
    .core_clk(core_clk),
    .nrst(nrst),
    .dif(dif)
  );

  // ******************************************************************
  // Rtc sampling and slow tick
  // ******************************************************************
  wire logic rtc_tick = rtc_s2 && !rtc_s3;
  wire logic div_wrap = div == 9'h1FF;
  wire logic next_slow = slow_sel ? rtc_tick : div_wrap; // RQ22

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rtc_s1 <= 1'b0;
      rtc_s2 <= 1'b0;
      rtc_s3 <= 1'b0;
      div <= 9'h000;
    end else begin
      rtc_s1 <= rtc_domain_clock;
      rtc_s2 <= rtc_s1;
      rtc_s3 <= rtc_s2;
      div <= div + 9'h001; // RQ22
    end
  end

  // ******************************************************************
  // Mode state machine
  // ******************************************************************
  wire logic [11:0] settle_units = {settle, 4'h0}; // RQ20
  wire logic settle_done = cnt >= {4'h0, settle_units}; // RQ20
  wire logic lock_done = cnt >= lock_cnt; // RQ16
  wire logic stopped = state == lpmc_pkg::ST_SLEEP || state == lpmc_pkg::ST_OSC;

  always_comb begin
    next_state = state;
    case (state)
      lpmc_pkg::ST_RUN: begin
        if (take_idle) begin
          next_state = lpmc_pkg::ST_IDLE_WAIT;
        end else if (take_sleep) begin
          next_state = lpmc_pkg::ST_DRAIN; // RQ13
        end
      end
      lpmc_pkg::ST_IDLE_WAIT: begin
        if (irq) begin
          next_state = lpmc_pkg::ST_RUN;
        end else if (cpu_op_done) begin
          next_state = lpmc_pkg::ST_IDLE; // RQ10
        end
      end
      lpmc_pkg::ST_IDLE: begin
        if (irq) begin
          next_state = lpmc_pkg::ST_RUN; // RQ11
        end
      end
      lpmc_pkg::ST_DRAIN: begin
        if (bus_idle) begin
          next_state = lpmc_pkg::ST_SREF; // RQ13
        end
      end
      lpmc_pkg::ST_SREF: begin
        if (bus_idle && sdram_sr_ack) begin
          next_state = lpmc_pkg::ST_SLEEP; // RQ14
        end
      end
      lpmc_pkg::ST_SLEEP: begin
        if (irq) begin
          next_state = keep_osc ? lpmc_pkg::ST_LOCK : lpmc_pkg::ST_OSC; // RQ15
        end
      end
      lpmc_pkg::ST_OSC: begin
        if (settle_done) begin
          next_state = lpmc_pkg::ST_LOCK; // RQ20
        end
      end
      lpmc_pkg::ST_LOCK: begin
        if (lock_done) begin
          next_state = lpmc_pkg::ST_RUN; // RQ16
        end
      end
      default: begin
        next_state = lpmc_pkg::ST_RUN;
      end
    endcase
  end

  // Counter only moves while waiting, so it never wraps in other states
  wire logic cnt_step = (state == lpmc_pkg::ST_OSC && rtc_tick) || state == lpmc_pkg::ST_LOCK;
  wire logic [15:0] next_cnt = next_state != state ? 16'h0000 :
    (cnt_step ? cnt + 16'h0001 : cnt);

  // ******************************************************************
  // Registers and state
  // ******************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lpc <= lpmc_pkg::LPC_RESET;
      pcg <= lpmc_pkg::PCG_RESET; // RQ18
      opc <= lpmc_pkg::OPC_RESET; // RQ20
      lock_time <= lpmc_pkg::LOCK_RESET;
      state <= lpmc_pkg::ST_RUN;
      cnt <= 16'h0000;
    end else begin
      lpc <= next_lpc;
      pcg <= wr_pcg ? reg_wdata & lpmc_pkg::PCG_MASK : pcg;
      opc <= wr_opc ? reg_wdata & lpmc_pkg::OPC_MASK : opc;
      lock_time <= wr_lock ? reg_wdata & lpmc_pkg::LOCK_MASK : lock_time;
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ******************************************************************
  // Output decode
  // ******************************************************************
  wire logic next_sys = !stopped && state != lpmc_pkg::ST_LOCK; // RQ6 RQ12
  wire logic next_cpu = in_run ? (!doze || dif.clk_on) :
    state == lpmc_pkg::ST_IDLE_WAIT; // RQ1 RQ5 RQ10
  wire logic next_halt = !in_run || (doze && !dif.clk_on); // RQ7 RQ24
  wire logic next_hold = !in_run && state != lpmc_pkg::ST_IDLE_WAIT &&
    state != lpmc_pkg::ST_IDLE; // RQ13
  wire logic next_srq = next_hold && state != lpmc_pkg::ST_DRAIN; // RQ13
  wire logic [28:0] udc_mask = 29'h0000_0001 << lpmc_pkg::UDC_BIT;
  wire logic [28:0] eff_gate = udc_suspend ? gate : gate & ~udc_mask; // RQ19
  wire logic [28:0] next_pclk = next_sys ? ~eff_gate : 29'h0000_0000; // RQ18
  wire logic next_osc = !(state == lpmc_pkg::ST_SLEEP && !keep_osc); // RQ21

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
      cpu_clk_en <= 1'b1;
      cpu_halt <= 1'b0;
      sys_clk_en <= 1'b1;
      pll_en <= 1'b1;
      clock_output_pin_en <= 1'b1;
      osc_en <= 1'b1;
      arb_hold <= 1'b0;
      sdram_sr_req <= 1'b0;
      periph_clk_en <= {29{1'b1}};
      periph_access_block <= 29'h0000_0000;
      slow_tick <= 1'b0;
      usb_phy_force <= 1'b0;
      bypass_select <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      cpu_clk_en <= next_cpu;
      cpu_halt <= next_halt;
      sys_clk_en <= next_sys;
      pll_en <= !stopped; // RQ12 RQ16
      clock_output_pin_en <= next_sys; // RQ12
      osc_en <= next_osc;
      arb_hold <= next_hold;
      sdram_sr_req <= next_srq;
      periph_clk_en <= next_pclk;
      periph_access_block <= gate; // RQ18
      slow_tick <= next_slow;
      usb_phy_force <= !opc[lpmc_pkg::SPN_BIT]; // RQ23
      bypass_select <= opc[lpmc_pkg::BPM_BIT];
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_sref_ok;
    state == lpmc_pkg::ST_SREF && bus_idle && sdram_sr_ack;
  endsequence
  sequence s_lock_end;
    state == lpmc_pkg::ST_LOCK ##1 state == lpmc_pkg::ST_RUN;
  endsequence
  sequence s_osc_end;
    state == lpmc_pkg::ST_OSC ##1 state == lpmc_pkg::ST_LOCK;
  endsequence

  doze_self_clear_a: assert property (doze && irq && !wr_lpc |=> !doze) // RQ4
    else $error("doze bit kept after cancel");
  doze_cont_clk_a: assert property (in_run && !doze ##1 in_run |=> cpu_clk_en) // RQ5
    else $error("cpu clock gated outside doze");
  doze_sys_run_a: assert property (in_run && doze |=> sys_clk_en && pll_en) // RQ6
    else $error("system clock lost in doze");
  idle_stop_a: assert property (state == lpmc_pkg::ST_IDLE |=> !cpu_clk_en && sys_clk_en) // RQ10
    else $error("idle clocks wrong");
  idle_wake_a: assert property (state == lpmc_pkg::ST_IDLE && irq |=> in_run ##1 cpu_clk_en) // RQ11
    else $error("idle not left on interrupt");
  sleep_entry_a: assert property ($rose(state == lpmc_pkg::ST_SLEEP) |-> $past(bus_idle)
    && $past(sdram_sr_ack) && sdram_sr_req) // RQ14
    else $error("clocks stopped before bus and memory ready");
  sleep_off_a: assert property (state == lpmc_pkg::ST_SLEEP |=>
    !sys_clk_en && !pll_en && !clock_output_pin_en && arb_hold) // RQ12
    else $error("clock running in sleep");
  sref_step_a: assert property (s_sref_ok |=> state == lpmc_pkg::ST_SLEEP) // RQ13
    else $error("sleep not entered after self-refresh");
  lock_wait_a: assert property (s_lock_end |-> $past(cnt) >= lock_cnt && !sys_clk_en) // RQ16
    else $error("clocks released before lock time");
  osc_wait_a: assert property (s_osc_end |-> $past(cnt) >= {4'h0, settle_units}) // RQ20
    else $error("oscillator settle cut short");
  gate_stop_a: assert property (next_sys && gate[0] |=> !periph_clk_en[0]
    && periph_access_block[0]) // RQ18
    else $error("gated peripheral clock running");
  udc_run_a: assert property (next_sys && !gate[lpmc_pkg::UDC_BIT] |=>
    periph_clk_en[lpmc_pkg::UDC_BIT]) // RQ19
    else $error("usb clock stopped while not gated");
  halt_hold_a: assert property (!in_run |=> cpu_halt) // RQ24
    else $error("halt dropped before wake");
  osc_keep_a: assert property (state == lpmc_pkg::ST_SLEEP && keep_osc |=> osc_en) // RQ21
    else $error("oscillator stopped despite keep bit");
  idle_wait_run_a: assert property (state == lpmc_pkg::ST_IDLE_WAIT |=> cpu_clk_en) // RQ10
    else $error("cpu clock stopped before operation done");
  reserved_noop_a: assert property (in_run && sleep_req && pss[1] |=> in_run) // RQ9
    else $error("reserved state select acted on");
  doze_sleep_end_a: assert property (doze && sleep_req && !pss[1] && !wr_lpc |=> !doze) // RQ3
    else $error("doze kept after sleep instruction");
  slow_div_a: assert property (!slow_sel && div_wrap |=> slow_tick) // RQ22
    else $error("divided slow tick missing");
  phy_force_a: assert property (!opc[lpmc_pkg::SPN_BIT] |=> usb_phy_force) // RQ23
    else $error("usb phy suspend not forced");
  lock_pll_on_a: assert property (state == lpmc_pkg::ST_LOCK |=> pll_en && !sys_clk_en) // RQ16
    else $error("pll off or clocks early during lock wait");
  sleep_periph_a: assert property (stopped |=> periph_clk_en == 29'h0000_0000) // RQ12
    else $error("peripheral clock running in sleep");
  slot_halt_a: assert property (in_run && doze && !dif.clk_on |=> cpu_halt && !cpu_clk_en) // RQ7
    else $error("cpu not halted after slot expiry");
endmodule
`default_nettype wire

//--- dv/lpmc_far_model.sv
// Purpose: CPU core, bus arbiter and SDRAM controller seen from the controller
// Assumes: lag cycles of delay before each acknowledge
// Notes: bus toggles busy and idle while not held, so a drain must really wait
`timescale 1ns/10ps
`default_nettype none
module lpmc_far_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic arb_hold,
  input wire logic sdram_sr_req,
  input wire logic cpu_halt,
  input wire logic [3:0] lag,
  output logic bus_idle,
  output logic sdram_sr_ack,
  output logic cpu_op_done
);
  // ****************************************************************
  // Delayed acknowledges
  // ****************************************************************
  logic [3:0] hold_cnt;
  logic [3:0] sr_cnt;
  logic [3:0] op_cnt;
  logic busy_tgl;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hold_cnt <= 4'h0;
      sr_cnt <= 4'h0;
      op_cnt <= 4'h0;
      busy_tgl <= 1'b0;
    end else begin
      hold_cnt <= !arb_hold ? 4'h0 : (hold_cnt == lag) ? hold_cnt : hold_cnt + 4'h1;
      sr_cnt <= !sdram_sr_req ? 4'h0 : (sr_cnt == lag) ? sr_cnt : sr_cnt + 4'h1;
      op_cnt <= !cpu_halt ? 4'h0 : (op_cnt == lag) ? op_cnt : op_cnt + 4'h1;
      busy_tgl <= ~busy_tgl;
    end
  end
  // Current access finishes only after lag cycles of hold
  assign bus_idle = arb_hold ? (hold_cnt == lag) : busy_tgl;
  assign sdram_sr_ack = sdram_sr_req && (sr_cnt == lag);
  assign cpu_op_done = cpu_halt && (op_cnt == lag);
endmodule
`default_nettype wire

//--- dv/tb_low_power_mode_controller.sv
// Purpose: self-checking bench of the low power mode controller
// Assumes: outputs registered, sampled at the edge before their update
// Notes: lock time set to 4 and settle to 1 to keep the run short
`timescale 1ns/10ps
`default_nettype none
module tb_low_power_mode_controller;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, sleep_req = 0, irq = 0;
  logic udc_suspend = 0, rtc_clk = 0;
  logic [31:0] reg_addr = 0, reg_wdata = 0, rdat, seed_v, v;
  wire logic [31:0] reg_rdata;
  wire logic [28:0] periph_clk_en, periph_access_block;
  wire logic cpu_clk_en, cpu_halt, sys_clk_en, pll_en, clock_output_pin_en, osc_en;
  wire logic arb_hold, sdram_sr_req, slow_tick, usb_phy_force, bypass_select;
  wire logic bus_idle, sdram_sr_ack, cpu_op_done;
  int fails = 0, tests_run = 0, cycles = 0, k, n_on, n_halt, n_sys, duty;
  logic [31:0] addr_t [5] = '{lpmc_pkg::LPC_ADDR, lpmc_pkg::PCG_ADDR, lpmc_pkg::OPC_ADDR,
    lpmc_pkg::LOCK_ADDR, 32'h1000_0008};
  logic [31:0] rst_t [5] = '{lpmc_pkg::LPC_RESET, lpmc_pkg::PCG_RESET, lpmc_pkg::OPC_RESET,
    lpmc_pkg::LOCK_RESET, 32'h0};
  lpmc_ctrl i_lpmc_ctrl (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_req(sleep_req), .cpu_op_done(cpu_op_done), .irq(irq), .bus_idle(bus_idle),
    .sdram_sr_ack(sdram_sr_ack), .udc_suspend(udc_suspend), .rtc_domain_clock(rtc_clk),
    .cpu_clk_en(cpu_clk_en), .cpu_halt(cpu_halt), .sys_clk_en(sys_clk_en), .pll_en(pll_en),
    .clock_output_pin_en(clock_output_pin_en), .osc_en(osc_en), .arb_hold(arb_hold),
    .sdram_sr_req(sdram_sr_req), .periph_clk_en(periph_clk_en),
    .periph_access_block(periph_access_block), .slow_tick(slow_tick),
    .usb_phy_force(usb_phy_force), .bypass_select(bypass_select));
  lpmc_far_model i_lpmc_far_model (.core_clk(core_clk), .nrst(nrst), .arb_hold(arb_hold),
    .sdram_sr_req(sdram_sr_req), .cpu_halt(cpu_halt), .lag(4'h6), .bus_idle(bus_idle),
    .sdram_sr_ack(sdram_sr_ack), .cpu_op_done(cpu_op_done));
  // ****************************************************************
  // Clocks, timeout and report
  // ****************************************************************
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    forever #50 rtc_clk = ~rtc_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic pulse_irq();
    irq <= 1'b1;
    @(posedge core_clk);
    irq <= 1'b0;
  endtask
  task automatic pulse_sleep();
    sleep_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    while (slow_tick !== 1'b1 && g < 700) begin
      @(posedge core_clk);
      g++;
    end
    g = 0;
    do begin
      @(posedge core_clk);
      g++;
    end while (slow_tick !== 1'b1 && g < 700);
  endtask
  function automatic logic [31:0] exp_clk(input logic [31:0] g, input logic s);
    logic [31:0] e;
    e = ~g & lpmc_pkg::PCG_MASK;
    e[10] = ~(g[10] & s);
    return e;
  endfunction
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    seed_v = $urandom(74438);
    wt(6);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      rd(addr_t[i], rdat);
      chk("reset_value", rst_t[i], rdat);
    end
    chk("periph_clk_en", 32'h1FFF_FFFF, periph_clk_en);
    wr(lpmc_pkg::PCG_ADDR, 32'hFFFF_FFFF);
    rd(lpmc_pkg::PCG_ADDR, rdat);
    chk("gate_mask", lpmc_pkg::PCG_MASK, rdat);
    wr(32'h1000_0008, 32'hFFFF_FFFF);
    rd(32'h1000_0008, rdat);
    chk("unmapped", 32'h0, rdat);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? lpmc_pkg::PCG_MASK : ($urandom & lpmc_pkg::PCG_MASK);
      udc_suspend <= i[0];
      wr(lpmc_pkg::PCG_ADDR, v);
      wt(2);
      chk("access_block", v, periph_access_block);
      chk("gated_clk", exp_clk(v, i[0]), periph_clk_en);
    end
    wr(lpmc_pkg::PCG_ADDR, 32'h0);
    for (int i = 0; i < 5; i++) begin
      duty = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(30, 1);
      wr(lpmc_pkg::LPC_ADDR, duty << 3);
      wr(lpmc_pkg::LPC_ADDR, (duty << 3) | 4);
      wt(4);
      n_on = 0;
      n_halt = 0;
      n_sys = 0;
      repeat (31) begin
        @(posedge core_clk);
        n_on += cpu_clk_en;
        n_halt += cpu_halt;
        n_sys += sys_clk_en;
      end
      chk("doze_on", duty, n_on);
      chk("doze_halt", 31 - duty, n_halt);
      chk("doze_sys", 31, n_sys);
      if (i[0]) pulse_irq();
      else wr(lpmc_pkg::LPC_ADDR, duty << 3);
      wt(3);
      n_on = 0;
      repeat (31) begin
        @(posedge core_clk);
        n_on += cpu_clk_en;
      end
      chk("after_cancel", 31, n_on);
      rd(lpmc_pkg::LPC_ADDR, rdat);
      chk("doze_cleared", duty << 3, rdat);
    end
    wr(lpmc_pkg::LPC_ADDR, 32'h0);
    wr(lpmc_pkg::LPC_ADDR, 32'h4);
    wt(4);
    pulse_sleep();
    wt(4);
    chk("idle_wait_clk", 1, cpu_clk_en);
    rd(lpmc_pkg::LPC_ADDR, rdat);
    chk("sleep_cancel", 32'h0, rdat);
    k = 0;
    while (cpu_clk_en !== 1'b0 && k < 30) begin
      @(posedge core_clk);
      k++;
    end
    chk("idle_stop", 1, k < 30);
    chk("idle_sys", 1, sys_clk_en & pll_en);
    chk("idle_halt", 1, cpu_halt);
    pulse_irq();
    wt(3);
    chk("idle_exit", 2'b01, {cpu_halt, cpu_clk_en});
    for (int s = 2; s < 4; s++) begin
      wr(lpmc_pkg::LPC_ADDR, s);
      pulse_sleep();
      wt(5);
      chk("reserved_mode", 2'b01, {cpu_halt, cpu_clk_en});
    end
    wr(lpmc_pkg::LOCK_ADDR, 32'h4);
    for (int kp = 0; kp < 2; kp++) begin
      // Peripheral gates were all cleared above, so sleep alone stops their clocks
      wr(lpmc_pkg::OPC_ADDR, 32'h100 | (kp << 4) | (kp << 5) | (kp << 6));
      wt(2);
      chk("phy_force", !kp, usb_phy_force);
      chk("bypass", kp, bypass_select);
      wr(lpmc_pkg::LPC_ADDR, 32'h1);
      pulse_sleep();
      k = 0;
      while (sys_clk_en !== 1'b0 && k < 100) begin
        @(posedge core_clk);
        k++;
      end
      chk("drain_wait", 1, k >= 11 && k < 100);
      chk("sleep_bus", 2'b11, {arb_hold, sdram_sr_req});
      chk("sleep_clks", 32'h0, {pll_en, clock_output_pin_en, periph_clk_en});
      chk("sleep_osc", kp, osc_en);
      chk("sleep_halt", 1, cpu_halt);
      pulse_irq();
      k = 0;
      while (pll_en !== 1'b1 && k < 400) begin
        @(posedge core_clk);
        k++;
      end
      chk("osc_settle", 1, kp ? (k < 20) : (k >= 180 && k < 400));
      k = 0;
      while (sys_clk_en !== 1'b1 && k < 100) begin
        @(posedge core_clk);
        k++;
      end
      chk("pll_lock", 1, k >= 4 && k < 100);
      wt(3);
      chk("wake_state", 3'b000, {arb_hold, sdram_sr_req, cpu_halt});
    end
    wr(lpmc_pkg::OPC_ADDR, 32'h40);
    tick_gap(k);
    tick_gap(k);
    chk("div512_gap", 512, k);
    wr(lpmc_pkg::OPC_ADDR, 32'h44);
    tick_gap(k);
    tick_gap(k);
    chk("rtc_gap", 1, k >= 12 && k <= 13);
    wr(lpmc_pkg::PCG_ADDR, lpmc_pkg::PCG_MASK);
    wr(lpmc_pkg::LPC_ADDR, 32'h4);
    wt(4);
    nrst <= 1'b0;
    wt(2);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk("reset_cpu_clk", 1, cpu_clk_en);
    chk("reset_gate", 32'h1FFF_FFFF, periph_clk_en);
    rd(lpmc_pkg::LPC_ADDR, rdat);
    chk("reset_lpc", lpmc_pkg::LPC_RESET, rdat);
    stop_test();
  end
endmodule
`default_nettype wire
